// >>> wdri_watchdog_regs.sv
// Windowed watchdog with its AHB-Lite register slave, in one module.
// Assumes startup values from the nonvolatile user row are stable at reset release,
// and that hresetn is the power-on reset.
`timescale 1ns/100ps
module wdri_watchdog_regs #(
    parameter int ADDR_W = 12,
    parameter int COUNT_DIV = wdri_pkg::COUNT_DIV_DEFAULT
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic nv_locked_run,
    input wire logic nv_window_en,
    input wire logic nv_enable,
    input wire logic [3:0] nv_window_sel,
    input wire logic [3:0] nv_timeout_length_sel,
    input wire logic [3:0] nv_warning_offset,
    input wire logic access_guard_on,
    output logic irq,
    output logic sys_reset_req
);
    localparam int BUSY_WAIT = COUNT_DIV + 1;

    logic loaded_reg;
    logic locked_run_reg, window_en_reg, enable_reg;
    logic [3:0] window_sel_reg, timeout_length_sel_reg, warning_offset_reg;
    logic early_warning_ie_reg, early_warning_reg;
    logic crossing_pending_reg;
    logic [7:0] kick_value_reg;
    logic kick_pending_reg;
    logic ap_valid_reg, ap_write_reg, ap_lane0_reg, ap_mapped_reg;
    logic [3:0] ap_idx_reg;
    logic hreadyout_reg, irq_reg, sys_reset_reg;
    logic [31:0] hrdata_reg;
    logic [15:0] div_cnt_reg;
    logic count_tick;
    logic cd_enable_reg, cd_window_en_reg;
    logic [3:0] cd_window_sel_reg, cd_timeout_sel_reg;
    logic closed_phase_reg;
    logic [13:0] count_reg;
    logic [3:0] cur_idx;
    logic cur_mapped, cur_lane0, take_ap, wr_go, wr_ok, sync_wr_now, busy_clear;
    logic active, ew_hit;
    logic [7:0] rd_byte;

    // Last count index of a doubling length code, saturating at the top code
    function automatic logic [13:0] len_last(input logic [3:0] code);
        logic [3:0] c;
        c = (code > wdri_pkg::LEN_CODE_MAX) ? wdri_pkg::LEN_CODE_MAX : code;
        return 14'((15'h0008 << c) - 15'h0001);
    endfunction : len_last

    // Address phase decode; byte lane 0 carries every register
    assign cur_idx = haddr[5:2];
    assign cur_mapped = (haddr[ADDR_W-1:6] == '0) && (cur_idx <= wdri_pkg::IDX_KICK_KEY);
    assign cur_lane0 = (hsize == wdri_pkg::HSIZE_BYTE) ? (haddr[1:0] == 2'h0) :
                       (hsize == wdri_pkg::HSIZE_HALF) ? !haddr[1] : 1'b1;
    assign take_ap = hsel && hready && htrans[1] && loaded_reg;
    assign wr_go = ap_valid_reg && ap_write_reg && hreadyout_reg;
    assign wr_ok = wr_go && ap_lane0_reg && ap_mapped_reg &&
                   (!access_guard_on || ap_idx_reg == wdri_pkg::IDX_IRQ_PENDING);
    assign sync_wr_now = wr_ok && (ap_idx_reg == wdri_pkg::IDX_CONTROL ||
                         ap_idx_reg == wdri_pkg::IDX_PERIOD_SETUP ||
                         ap_idx_reg == wdri_pkg::IDX_KICK_KEY);
    assign busy_clear = crossing_pending_reg && count_tick;

    // Read multiplexer; reserved bits and unmapped words read zero
    always_comb
    begin
        rd_byte = wdri_pkg::RESET_BYTE;
        case (cur_idx)
            wdri_pkg::IDX_CONTROL: rd_byte = {locked_run_reg, 4'h0, window_en_reg,
                                              enable_reg, 1'b0};
            wdri_pkg::IDX_PERIOD_SETUP: rd_byte = {window_sel_reg, timeout_length_sel_reg};
            wdri_pkg::IDX_WARNING_OFFSET: rd_byte = {4'h0, warning_offset_reg};
            wdri_pkg::IDX_IRQ_MASK_OFF: rd_byte = {7'h00, early_warning_ie_reg};
            wdri_pkg::IDX_IRQ_MASK_ON: rd_byte = {7'h00, early_warning_ie_reg};
            wdri_pkg::IDX_IRQ_PENDING: rd_byte = {7'h00, early_warning_reg};
            wdri_pkg::IDX_SYNC_STATE: rd_byte = {crossing_pending_reg, 7'h00};
            default: rd_byte = wdri_pkg::RESET_BYTE;
        endcase
    end

    // Bus address phase capture and read data
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_valid_reg <= 1'b0;
            ap_write_reg <= 1'b0;
            ap_lane0_reg <= 1'b0;
            ap_mapped_reg <= 1'b0;
            ap_idx_reg <= 4'h0;
            hrdata_reg <= 32'h0000_0000;
        end
        else if (hready)
        begin
            ap_valid_reg <= take_ap;
            ap_write_reg <= hwrite;
            ap_lane0_reg <= cur_lane0;
            ap_mapped_reg <= cur_mapped;
            ap_idx_reg <= cur_idx;
            hrdata_reg <= (take_ap && !hwrite && cur_mapped) ? {24'h00_0000, rd_byte} : '0;
        end
    end

    // Wait states: a synchronised write waits while a crossing is in flight
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hreadyout_reg <= 1'b1;
        else if (take_ap && hwrite && (cur_idx == wdri_pkg::IDX_CONTROL ||
                 cur_idx == wdri_pkg::IDX_PERIOD_SETUP || cur_idx == wdri_pkg::IDX_KICK_KEY))
            hreadyout_reg <= !((crossing_pending_reg && !busy_clear) || sync_wr_now);
        else if (!hreadyout_reg)
            hreadyout_reg <= busy_clear;
    end

    // Startup load flag
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            loaded_reg <= 1'b0;
        else
            loaded_reg <= 1'b1;
    end

    // Control register bits
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            locked_run_reg <= 1'b0;
            window_en_reg <= 1'b0;
            enable_reg <= 1'b0;
        end
        else if (!loaded_reg)
        begin
            locked_run_reg <= nv_locked_run;
            window_en_reg <= nv_window_en;
            enable_reg <= nv_enable;
        end
        else if (wr_ok && ap_idx_reg == wdri_pkg::IDX_CONTROL)
        begin
            locked_run_reg <= locked_run_reg | hwdata[wdri_pkg::LOCKED_RUN_BIT];
            if (!enable_reg || locked_run_reg)
                window_en_reg <= hwdata[wdri_pkg::WINDOW_EN_BIT];
            if (!locked_run_reg)
                enable_reg <= hwdata[wdri_pkg::ENABLE_BIT];
        end
    end

    // Period setup and warning offset, enable-guarded
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            window_sel_reg <= 4'h0;
            timeout_length_sel_reg <= 4'h0;
            warning_offset_reg <= 4'h0;
        end
        else if (!loaded_reg)
        begin
            window_sel_reg <= nv_window_sel;
            timeout_length_sel_reg <= nv_timeout_length_sel;
            warning_offset_reg <= nv_warning_offset;
        end
        else if (wr_ok && !enable_reg && !locked_run_reg)
        begin
            if (ap_idx_reg == wdri_pkg::IDX_PERIOD_SETUP)
            begin
                window_sel_reg <= hwdata[wdri_pkg::WINDOW_SEL_LSB +: 4];
                timeout_length_sel_reg <= hwdata[3:0];
            end
            if (ap_idx_reg == wdri_pkg::IDX_WARNING_OFFSET)
                warning_offset_reg <= hwdata[3:0];
        end
    end

    // Early warning interrupt enable, shared by mask-off and mask-on
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            early_warning_ie_reg <= 1'b0;
        else if (wr_ok && ap_idx_reg == wdri_pkg::IDX_IRQ_MASK_OFF &&
                 hwdata[wdri_pkg::EARLY_WARNING_BIT])
            early_warning_ie_reg <= 1'b0;
        else if (wr_ok && ap_idx_reg == wdri_pkg::IDX_IRQ_MASK_ON &&
                 hwdata[wdri_pkg::EARLY_WARNING_BIT])
            early_warning_ie_reg <= 1'b1;
    end

    // Kick value capture and crossing busy flag
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            crossing_pending_reg <= 1'b0;
            kick_pending_reg <= 1'b0;
            kick_value_reg <= 8'h00;
        end
        else
        begin
            if (sync_wr_now)
                crossing_pending_reg <= 1'b1;
            else if (busy_clear)
                crossing_pending_reg <= 1'b0;
            if (wr_ok && ap_idx_reg == wdri_pkg::IDX_KICK_KEY)
            begin
                kick_pending_reg <= 1'b1;
                kick_value_reg <= hwdata[7:0];
            end
            else if (busy_clear)
                kick_pending_reg <= 1'b0;
        end
    end

    // Count clock enable divider
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            div_cnt_reg <= 16'h0000;
        else if (div_cnt_reg == 16'(COUNT_DIV - 1))
            div_cnt_reg <= 16'h0000;
        else
            div_cnt_reg <= div_cnt_reg + 16'h0001;
    end
    assign count_tick = (div_cnt_reg == 16'(COUNT_DIV - 1)) && loaded_reg;

    // Count side copies of synchronised settings
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cd_enable_reg <= 1'b0;
            cd_window_en_reg <= 1'b0;
            cd_window_sel_reg <= 4'h0;
            cd_timeout_sel_reg <= 4'h0;
        end
        else if (!loaded_reg || busy_clear)
        begin
            cd_enable_reg <= loaded_reg ? enable_reg : nv_enable;
            cd_window_en_reg <= loaded_reg ? window_en_reg : nv_window_en;
            cd_window_sel_reg <= loaded_reg ? window_sel_reg : nv_window_sel;
            cd_timeout_sel_reg <= loaded_reg ? timeout_length_sel_reg : nv_timeout_length_sel;
        end
    end

    assign active = cd_enable_reg || locked_run_reg;
    assign ew_hit = !cd_window_en_reg && (count_reg == len_last(warning_offset_reg));

    // Watchdog counter, window phase and system reset request
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count_reg <= 14'h0000;
            closed_phase_reg <= 1'b0;
            sys_reset_reg <= 1'b0;
        end
        else
        begin
            sys_reset_reg <= 1'b0;
            if (count_tick)
            begin
                if (!active)
                begin
                    count_reg <= 14'h0000;
                    closed_phase_reg <= 1'b1; // Park at closed start; only read in window mode
                end
                else if (busy_clear && kick_pending_reg)
                begin
                    sys_reset_reg <= (kick_value_reg != wdri_pkg::KICK_KEY) ||
                                     (cd_window_en_reg && closed_phase_reg);
                    count_reg <= 14'h0000;
                    closed_phase_reg <= cd_window_en_reg;
                end
                else if (cd_window_en_reg && closed_phase_reg)
                begin
                    if (count_reg >= len_last(cd_window_sel_reg))
                    begin
                        count_reg <= 14'h0000;
                        closed_phase_reg <= 1'b0;
                    end
                    else
                        count_reg <= count_reg + 14'h0001;
                end
                else if (count_reg == len_last(cd_timeout_sel_reg))
                begin
                    sys_reset_reg <= 1'b1;
                    count_reg <= 14'h0000;
                    closed_phase_reg <= cd_window_en_reg;
                end
                else
                    count_reg <= count_reg + 14'h0001;
            end
        end
    end

    // Early warning flag; a hardware set wins over a software clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            early_warning_reg <= 1'b0;
        else if (count_tick && active && !(busy_clear && kick_pending_reg) &&
                 (ew_hit || (cd_window_en_reg && closed_phase_reg &&
                  count_reg >= len_last(cd_window_sel_reg))))
            early_warning_reg <= 1'b1;
        else if (wr_ok && ap_idx_reg == wdri_pkg::IDX_IRQ_PENDING &&
                 hwdata[wdri_pkg::EARLY_WARNING_BIT])
            early_warning_reg <= 1'b0;
    end

    // Interrupt request
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_reg <= 1'b0;
        else
            irq_reg <= early_warning_reg && early_warning_ie_reg;
    end

    assign hreadyout = hreadyout_reg;
    assign hrdata = hrdata_reg;
    assign hresp = 1'b0;
    assign irq = irq_reg;
    assign sys_reset_req = sys_reset_reg;

    property p_lock_sticky;
        @(posedge hclk) disable iff (!hresetn || !loaded_reg)
        locked_run_reg |=> locked_run_reg;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock-on bit dropped");

    property p_lock_freeze;
        @(posedge hclk) disable iff (!hresetn || !loaded_reg)
        locked_run_reg |=> $stable(timeout_length_sel_reg) && $stable(warning_offset_reg);
    endproperty
    a_lock_freeze: assert property (p_lock_freeze) else $error("setup changed under lock");

    property p_wen_guard;
        @(posedge hclk) disable iff (!hresetn || !loaded_reg)
        enable_reg && !locked_run_reg |=> $stable(window_en_reg);
    endproperty
    a_wen_guard: assert property (p_wen_guard) else $error("window enable changed");

    property p_enable_lock;
        @(posedge hclk) disable iff (!hresetn || !loaded_reg)
        locked_run_reg |=> $stable(enable_reg);
    endproperty
    a_enable_lock: assert property (p_enable_lock) else $error("enable changed under lock");

    property p_busy_bound;
        @(posedge hclk) disable iff (!hresetn)
        $rose(crossing_pending_reg) |-> ##[1:BUSY_WAIT] !crossing_pending_reg;
    endproperty
    a_busy_bound: assert property (p_busy_bound) else $error("busy flag stuck");

    property p_busy_set;
        @(posedge hclk) disable iff (!hresetn)
        wr_ok && ap_idx_reg == wdri_pkg::IDX_CONTROL |=> crossing_pending_reg;
    endproperty
    a_busy_set: assert property (p_busy_set) else $error("busy not raised");

    property p_mask_off;
        @(posedge hclk) disable iff (!hresetn)
        wr_ok && ap_idx_reg == wdri_pkg::IDX_IRQ_MASK_OFF && hwdata[0] |=> !early_warning_ie_reg;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("mask-off ignored");

    property p_guard;
        @(posedge hclk) disable iff (!hresetn || !loaded_reg)
        access_guard_on && wr_go |=> $stable(enable_reg) && $stable(early_warning_ie_reg);
    endproperty
    a_guard: assert property (p_guard) else $error("write passed the guard");

    property p_bad_key;
        @(posedge hclk) disable iff (!hresetn)
        count_tick && active && busy_clear && kick_pending_reg &&
        kick_value_reg != wdri_pkg::KICK_KEY |=> sys_reset_req;
    endproperty
    a_bad_key: assert property (p_bad_key) else $error("wrong key did not reset");

    property p_irq;
        @(posedge hclk) disable iff (!hresetn)
        early_warning_reg && early_warning_ie_reg |=> ##0 irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt request missing");

    property p_rsvd;
        @(posedge hclk) disable iff (!hresetn)
        ap_valid_reg && !ap_write_reg |-> hrdata[31:8] == 24'h00_0000;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");

    c_window_reset: cover property (@(posedge hclk) cd_window_en_reg && sys_reset_req);
    c_warning_irq: cover property (@(posedge hclk) $rose(irq));
    c_stall: cover property (@(posedge hclk) ap_valid_reg && !hreadyout_reg);
endmodule : wdri_watchdog_regs

// >>> wdri_pkg.sv
// Constants for the windowed watchdog register block.
// Assumes a single 100 MHz bus clock; the count clock is an enable pulse.
package wdri_pkg;
    // Clock period of hclk in ns
    localparam int CLK_PERIOD_NS = 10;
    // Register indices; byte address is four times the index
    localparam logic [3:0] IDX_CONTROL = 4'h0;
    localparam logic [3:0] IDX_PERIOD_SETUP = 4'h1;
    localparam logic [3:0] IDX_WARNING_OFFSET = 4'h2;
    localparam logic [3:0] IDX_IRQ_MASK_OFF = 4'h4;
    localparam logic [3:0] IDX_IRQ_MASK_ON = 4'h5;
    localparam logic [3:0] IDX_IRQ_PENDING = 4'h6;
    localparam logic [3:0] IDX_SYNC_STATE = 4'h7;
    localparam logic [3:0] IDX_KICK_KEY = 4'h8;
    // Field positions
    localparam int LOCKED_RUN_BIT = 7;
    localparam int WINDOW_EN_BIT = 2;
    localparam int ENABLE_BIT = 1;
    localparam int WINDOW_SEL_LSB = 4;
    localparam int EARLY_WARNING_BIT = 0;
    localparam int CROSSING_PENDING_BIT = 7;
    // Values
    localparam logic [7:0] KICK_KEY = 8'ha5;
    localparam logic [3:0] LEN_CODE_MAX = 4'hb;
    localparam logic [13:0] LEN_MIN_LAST = 14'h0007;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_BYTE = 3'h0;
    localparam logic [2:0] HSIZE_HALF = 3'h1;
    // Default count clock divider in hclk cycles
    localparam int COUNT_DIV_DEFAULT = 4;
endpackage : wdri_pkg

// >>> tb_top.sv
// Self-checking bench for the windowed watchdog register block.
// Assumes one AHB-Lite master (this bench) and hready looped back from hreadyout.
`timescale 1ns/100ps
module tb_top;
    localparam int DIV = 4;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, sys_reset_req;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd, seed, ev, wv;
    logic nv_locked_run, nv_window_en, nv_enable, access_guard_on;
    logic [3:0] nv_window_sel, nv_timeout_length_sel, nv_warning_offset;
    int err_total = 0;
    int compares = 0;
    int pulses = 0;
    int p0, i;

    assign hready = hreadyout;

    wdri_watchdog_regs #(.ADDR_W(12), .COUNT_DIV(DIV)) u_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .nv_locked_run(nv_locked_run), .nv_window_en(nv_window_en), .nv_enable(nv_enable),
        .nv_window_sel(nv_window_sel), .nv_timeout_length_sel(nv_timeout_length_sel),
        .nv_warning_offset(nv_warning_offset), .access_guard_on(access_guard_on), .irq(irq),
        .sys_reset_req(sys_reset_req));

    // Clock generation
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // Count system reset request pulses
    always @(posedge hclk)
        if (sys_reset_req === 1'b1)
            pulses <= pulses + 1;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Keep length codes inside the defined range
    function automatic logic [3:0] code(input logic [3:0] v);
        return (v > wdri_pkg::LEN_CODE_MAX) ? v - 4'h4 : v;
    endfunction : code

    function automatic logic [31:0] exp_ctrl(input logic lock, input logic wen, input logic en);
        return {24'h000000, lock, 4'h0, wen, en, 1'b0};
    endfunction : exp_ctrl

    task automatic complete_run();
        $display("Mismatches %0d of %0d compares", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // One single transfer: address phase, then data phase, each held until ready
    task automatic bus(input logic [3:0] idx, input logic [1:0] lane, input logic [2:0] sz,
                       input logic wr_en, input logic [31:0] wd);
        @(posedge hclk);
        haddr <= {6'h00, idx, lane};
        htrans <= wdri_pkg::HTRANS_NONSEQ;
        hwrite <= wr_en;
        hsize <= sz;
        // Ready is sampled at the rising edge that ends each phase
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [3:0] idx, input logic [31:0] wd);
        bus(idx, 2'h0, 3'h2, 1'b1, wd);
    endtask : wr

    task automatic rchk(input logic [3:0] idx, input logic [31:0] exp);
        bus(idx, 2'h0, 3'h2, 1'b0, 32'h00000000);
        chk(rd, exp);
        chk({31'h0, hresp}, 32'h00000000);
    endtask : rchk

    // Poll the busy flag until the crossing has landed
    task automatic wait_sync();
        for (int n = 0; n < 40; n++)
        begin
            bus(wdri_pkg::IDX_SYNC_STATE, 2'h0, 3'h2, 1'b0, 32'h00000000);
            if (rd[7] === 1'b0) break;
        end
        chk(rd, 32'h00000000);
    endtask : wait_sync

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge hclk);
        err_total++;
        complete_run();
    end

    // Main sequence
    initial
    begin
        seed = lfsr(32'h00015c7f);
        hresetn = 1'b0;
        hsel = 1'b1;
        haddr = 12'h000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        access_guard_on = 1'b0;
        nv_locked_run = 1'b0;
        nv_enable = 1'b0;
        nv_window_en = seed[0];
        nv_window_sel = code(seed[11:8]);
        nv_timeout_length_sel = code(seed[7:4]);
        nv_warning_offset = code(seed[15:12]);
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        // Startup values and reserved places
        rchk(wdri_pkg::IDX_CONTROL, exp_ctrl(1'b0, nv_window_en, 1'b0));
        rchk(wdri_pkg::IDX_PERIOD_SETUP, {24'h0, nv_window_sel, nv_timeout_length_sel});
        rchk(wdri_pkg::IDX_WARNING_OFFSET, {28'h0, nv_warning_offset});
        rchk(wdri_pkg::IDX_IRQ_MASK_OFF, 32'h00000000);
        rchk(4'h3, 32'h00000000);
        // Random settings while disabled
        for (i = 0; i < 6; i++)
        begin
            seed = lfsr(seed);
            ev = {24'h0, code(seed[7:4]), code(seed[3:0])};
            wv = {28'h0, code(seed[11:8])};
            wr(wdri_pkg::IDX_PERIOD_SETUP, ev);
            rchk(wdri_pkg::IDX_PERIOD_SETUP, ev);
            wr(wdri_pkg::IDX_WARNING_OFFSET, wv);
            rchk(wdri_pkg::IDX_WARNING_OFFSET, wv);
        end
        // Byte lanes and access guard
        bus(wdri_pkg::IDX_WARNING_OFFSET, 2'h1, wdri_pkg::HSIZE_BYTE, 1'b1, 32'h00000500);
        rchk(wdri_pkg::IDX_WARNING_OFFSET, wv);
        bus(wdri_pkg::IDX_WARNING_OFFSET, 2'h0, wdri_pkg::HSIZE_HALF, 1'b1, 32'h00000003);
        rchk(wdri_pkg::IDX_WARNING_OFFSET, 32'h00000003);
        access_guard_on <= 1'b1;
        wr(wdri_pkg::IDX_WARNING_OFFSET, 32'h00000005);
        rchk(wdri_pkg::IDX_WARNING_OFFSET, 32'h00000003);
        access_guard_on <= 1'b0;
        // Shared interrupt enable
        wr(wdri_pkg::IDX_IRQ_MASK_ON, 32'h00000001);
        rchk(wdri_pkg::IDX_IRQ_MASK_OFF, 32'h00000001);
        wr(wdri_pkg::IDX_IRQ_MASK_OFF, 32'h00000000);
        rchk(wdri_pkg::IDX_IRQ_MASK_ON, 32'h00000001);
        wr(wdri_pkg::IDX_IRQ_MASK_OFF, 32'h00000001);
        rchk(wdri_pkg::IDX_IRQ_MASK_ON, 32'h00000000);
        wr(wdri_pkg::IDX_IRQ_MASK_ON, 32'h00000001);
        // Normal mode: 16-tick period, warning at 8 ticks
        wr(wdri_pkg::IDX_PERIOD_SETUP, 32'h00000001);
        wr(wdri_pkg::IDX_WARNING_OFFSET, 32'h00000000);
        wr(wdri_pkg::IDX_CONTROL, 32'h00000002);
        rchk(wdri_pkg::IDX_CONTROL, 32'h00000002);
        wait_sync();
        wr(wdri_pkg::IDX_PERIOD_SETUP, 32'h00000005);
        rchk(wdri_pkg::IDX_PERIOD_SETUP, 32'h00000001);
        wr(wdri_pkg::IDX_CONTROL, 32'h00000006);
        rchk(wdri_pkg::IDX_CONTROL, 32'h00000002);
        p0 = pulses;
        repeat (150) @(posedge hclk);
        chk(32'(pulses > p0), 32'h00000001);
        chk({31'h0, irq}, 32'h00000001);
        rchk(wdri_pkg::IDX_IRQ_PENDING, 32'h00000001);
        wr(wdri_pkg::IDX_KICK_KEY, 32'h000000a5);
        wr(wdri_pkg::IDX_IRQ_PENDING, 32'h00000001);
        rchk(wdri_pkg::IDX_IRQ_PENDING, 32'h00000000);
        repeat (36) @(posedge hclk);
        rchk(wdri_pkg::IDX_IRQ_PENDING, 32'h00000001);
        wr(wdri_pkg::IDX_IRQ_MASK_OFF, 32'h00000001);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h00000000);
        // Regular kicks hold off the reset; a wrong key forces one
        wr(wdri_pkg::IDX_KICK_KEY, 32'h000000a5);
        p0 = pulses;
        repeat (8)
        begin
            repeat (20) @(posedge hclk);
            wr(wdri_pkg::IDX_KICK_KEY, 32'h000000a5);
        end
        chk(32'(pulses - p0), 32'h00000000);
        p0 = pulses;
        wr(wdri_pkg::IDX_KICK_KEY, 32'h0000005a);
        repeat (20) @(posedge hclk);
        chk(32'(pulses - p0), 32'h00000001);
        wr(wdri_pkg::IDX_CONTROL, 32'h00000000);
        wait_sync();
        // Window mode: 16-tick closed window, 16-tick open window
        wr(wdri_pkg::IDX_PERIOD_SETUP, 32'h00000011);
        wr(wdri_pkg::IDX_CONTROL, 32'h00000006);
        wait_sync();
        p0 = pulses;
        wr(wdri_pkg::IDX_KICK_KEY, 32'h000000a5);
        repeat (10) @(posedge hclk);
        chk(32'(pulses - p0), 32'h00000001);
        repeat (70) @(posedge hclk);
        p0 = pulses;
        wr(wdri_pkg::IDX_KICK_KEY, 32'h000000a5);
        repeat (10) @(posedge hclk);
        chk(32'(pulses - p0), 32'h00000000);
        wr(wdri_pkg::IDX_CONTROL, 32'h00000000);
        wait_sync();
        // Lock-on: sticky, guards settings, keeps running
        wr(wdri_pkg::IDX_CONTROL, 32'h00000080);
        rchk(wdri_pkg::IDX_CONTROL, exp_ctrl(1'b1, 1'b0, 1'b0));
        wr(wdri_pkg::IDX_CONTROL, 32'h00000000);
        rchk(wdri_pkg::IDX_CONTROL, exp_ctrl(1'b1, 1'b0, 1'b0));
        wr(wdri_pkg::IDX_PERIOD_SETUP, 32'h00000022);
        rchk(wdri_pkg::IDX_PERIOD_SETUP, 32'h00000011);
        wr(wdri_pkg::IDX_CONTROL, 32'h00000084);
        rchk(wdri_pkg::IDX_CONTROL, exp_ctrl(1'b1, 1'b1, 1'b0));
        p0 = pulses;
        repeat (200) @(posedge hclk);
        chk(32'(pulses > p0), 32'h00000001);
        // Only a power-on reset lets go of lock-on; startup values return
        hresetn <= 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rchk(wdri_pkg::IDX_CONTROL, exp_ctrl(1'b0, nv_window_en, 1'b0));
        rchk(wdri_pkg::IDX_PERIOD_SETUP, {24'h0, nv_window_sel, nv_timeout_length_sel});
        complete_run();
    end
endmodule : tb_top
